// ---- verilog/sspc_serial_port.sv ----
`timescale 1ns/1ps
module sspc_serial_port (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// data-memory access
	input wire logic [7:0] memAddr,
	input wire logic memWrite,
	input wire logic [7:0] memWrData,
	input wire logic memRead,
	output logic [7:0] memRdData,
	// port g pins
	input wire logic [7:0] portIn,
	output logic [7:0] portOut,
	output logic [7:0] portOe,
	// status
	output logic busy
);
	logic [7:0] latchReg;
	logic [7:0] dirReg;
	logic [7:0] shiftReg;
	logic [7:0] ctrlReg;
	logic [7:0] statReg;
	logic [7:0] rdData;
	logic [7:0] pinMeta;
	logic [7:0] pinSync;
	logic skPrev;
	logic siLatch;
	logic soReg;
	logic pend;
	logic [3:0] bitCount;
	logic [7:0] next_latchReg;
	logic [7:0] next_dirReg;
	logic [7:0] next_shiftReg;
	logic [7:0] next_ctrlReg;
	logic [7:0] next_statReg;
	logic [7:0] next_rdData;
	logic next_siLatch;
	logic next_soReg;
	logic next_pend;
	logic [3:0] next_bitCount;
	logic idlePol;
	logic altPhase;
	logic funcSel;
	logic master;
	logic skInt;
	logic skLevel;
	logic riseEdge;
	logic fallEdge;
	logic driveOnRise;
	logic sampleEdge;
	logic driveEdge;
	logic [2:0] halfPeriod;
	logic wrBusy;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		hit = memWrite && (a == target);
	endfunction

	assign idlePol = latchReg[sspc_pkg::POL_BIT];
	assign altPhase = dirReg[sspc_pkg::PHASE_BIT];
	assign funcSel = ctrlReg[sspc_pkg::FUNC_SEL_BIT];
	assign master = dirReg[sspc_pkg::SK_BIT];
	assign busy = statReg[sspc_pkg::BUSY_BIT];

	// master rate decode, the high bit overrides the low one
	always_comb
	begin
		if (ctrlReg[sspc_pkg::RATE_HIGH_BIT])
			halfPeriod = sspc_pkg::HALF_SLOW;
		else if (ctrlReg[sspc_pkg::RATE_LOW_BIT])
			halfPeriod = sspc_pkg::HALF_MID;
		else
			halfPeriod = sspc_pkg::HALF_FAST;
	end

	sspc_sk_gen #(
		.CNT_W(3)
	) u_sk_gen (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.run(busy && master && funcSel),
		.idleLevel(idlePol),
		.halfPeriod(halfPeriod),
		.skOut(skInt)
	);

	// two-stage pin synchroniser; only the second stage is looked at
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pinMeta <= sspc_pkg::RESET_BYTE;
			pinSync <= sspc_pkg::RESET_BYTE;
			skPrev <= 1'b0;
		end
		else
		begin
			pinMeta <= portIn;
			pinSync <= pinMeta;
			skPrev <= skLevel;
		end
	end

	// edges of whichever clock is in charge
	assign skLevel = master ? skInt : pinSync[sspc_pkg::SK_BIT];
	assign riseEdge = skLevel && !skPrev;
	assign fallEdge = !skLevel && skPrev;
	// drive edge flips with both polarity and phase select
	assign driveOnRise = altPhase ^ idlePol;
	assign driveEdge = busy && funcSel && (driveOnRise ? riseEdge : fallEdge);
	assign sampleEdge = busy && funcSel && (driveOnRise ? fallEdge : riseEdge);
	assign wrBusy = hit(memAddr, sspc_pkg::ADDR_STATUS);

	// register writes, read capture and the shift engine
	always_comb
	begin
		next_latchReg = latchReg;
		next_dirReg = dirReg;
		next_shiftReg = shiftReg;
		next_ctrlReg = ctrlReg;
		next_statReg = statReg;
		next_rdData = rdData;
		next_siLatch = siLatch;
		next_soReg = soReg;
		next_pend = pend;
		next_bitCount = bitCount;
		// the phase-leading drive mode has no drive behind its last sample
		if (sampleEdge)
		begin
			next_siLatch = pinSync[sspc_pkg::SI_BIT];
			next_pend = 1'b1;
			if (altPhase && bitCount == sspc_pkg::BITS_PER_XFER - 4'h1)
			begin
				next_shiftReg = {shiftReg[6:0], pinSync[sspc_pkg::SI_BIT]};
				next_bitCount = sspc_pkg::BITS_PER_XFER;
				next_statReg[sspc_pkg::BUSY_BIT] = 1'b0;
				next_pend = 1'b0;
			end
		end
		if (driveEdge && pend)
		begin
			next_shiftReg = {shiftReg[6:0], siLatch};
			next_soReg = shiftReg[6];
			next_bitCount = bitCount + 4'h1;
			next_pend = 1'b0;
			if (bitCount == sspc_pkg::BITS_PER_XFER - 4'h1)
				next_statReg[sspc_pkg::BUSY_BIT] = 1'b0;
		end
		if (hit(memAddr, sspc_pkg::ADDR_G_LATCH))
			next_latchReg = memWrData;
		if (hit(memAddr, sspc_pkg::ADDR_G_DIR))
			next_dirReg = memWrData;
		if (hit(memAddr, sspc_pkg::ADDR_CTRL))
			next_ctrlReg = memWrData;
		// loading mid-transfer is unsafe for the peer, so only idle loads touch the output
		if (hit(memAddr, sspc_pkg::ADDR_SHIFT))
		begin
			next_shiftReg = memWrData;
			if (!busy)
				next_soReg = memWrData[7];
		end
		// a start or an early stop by software wins over a hardware clear
		if (wrBusy)
		begin
			next_statReg = memWrData;
			if (memWrData[sspc_pkg::BUSY_BIT] && !busy)
			begin
				next_bitCount = 4'h0;
				next_pend = 1'b0;
				next_soReg = shiftReg[7];
			end
		end
		if (memRead)
		begin
			unique case (memAddr)
				sspc_pkg::ADDR_G_LATCH: next_rdData = latchReg;
				sspc_pkg::ADDR_G_DIR: next_rdData = dirReg;
				sspc_pkg::ADDR_G_PINS: next_rdData = pinSync;
				sspc_pkg::ADDR_SHIFT: next_rdData = shiftReg;
				sspc_pkg::ADDR_CTRL: next_rdData = ctrlReg;
				sspc_pkg::ADDR_STATUS: next_rdData = statReg;
				default: next_rdData = sspc_pkg::UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			latchReg <= sspc_pkg::RESET_BYTE;
			dirReg <= sspc_pkg::RESET_BYTE;
			shiftReg <= sspc_pkg::RESET_BYTE;
			ctrlReg <= sspc_pkg::RESET_BYTE;
			statReg <= sspc_pkg::RESET_BYTE;
			rdData <= sspc_pkg::RESET_BYTE;
			siLatch <= 1'b0;
			soReg <= 1'b0;
			pend <= 1'b0;
			bitCount <= 4'h0;
		end
		else
		begin
			latchReg <= next_latchReg;
			dirReg <= next_dirReg;
			shiftReg <= next_shiftReg;
			ctrlReg <= next_ctrlReg;
			statReg <= next_statReg;
			rdData <= next_rdData;
			siLatch <= next_siLatch;
			soReg <= next_soReg;
			pend <= next_pend;
			bitCount <= next_bitCount;
		end
	end

	assign memRdData = rdData;

	// pin muxing: serial functions only while selected, input pin never driven then
	always_comb
	begin
		portOut = latchReg;
		portOe = dirReg;
		if (funcSel)
		begin
			portOut[sspc_pkg::SO_BIT] = soReg;
			portOut[sspc_pkg::SK_BIT] = skInt;
			portOe[sspc_pkg::SI_BIT] = 1'b0;
		end
	end
endmodule

// ---- verilog/sspc_pkg.sv ----
package sspc_pkg;
	// data-memory addresses of the port and serial registers
	localparam logic [7:0] ADDR_G_LATCH = 8'hd4;
	localparam logic [7:0] ADDR_G_DIR = 8'hd5;
	localparam logic [7:0] ADDR_G_PINS = 8'hd6;
	localparam logic [7:0] ADDR_SHIFT = 8'he9;
	localparam logic [7:0] ADDR_CTRL = 8'hee;
	localparam logic [7:0] ADDR_STATUS = 8'hef;
	// port g pin roles
	localparam int SO_BIT = 4;
	localparam int SK_BIT = 5;
	localparam int SI_BIT = 6;
	// idle polarity lives in the latch, phase select in the direction register
	localparam int POL_BIT = 5;
	localparam int PHASE_BIT = 6;
	// control and status fields
	localparam int RATE_LOW_BIT = 0;
	localparam int RATE_HIGH_BIT = 1;
	localparam int FUNC_SEL_BIT = 3;
	localparam int BUSY_BIT = 2;
	// reset values and the value read from unmapped addresses
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	// bits per transfer and master half periods in instruction cycles
	localparam logic [3:0] BITS_PER_XFER = 4'h8;
	localparam logic [2:0] HALF_FAST = 3'h1;
	localparam logic [2:0] HALF_MID = 3'h2;
	localparam logic [2:0] HALF_SLOW = 3'h4;
endpackage

// ---- verilog/sspc_sk_gen.sv ----
`timescale 1ns/1ps
module sspc_sk_gen #(
	parameter int CNT_W = 3
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// control
	input wire logic run,
	input wire logic idleLevel,
	input wire logic [CNT_W-1:0] halfPeriod,
	// generated shift clock
	output logic skOut
);
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic level;
	logic next_level;

	// the slowest rate needs a half period of four, so three bits at least
	if (CNT_W < 3)
	begin
		$error("sspc_sk_gen: counter too narrow for the slowest rate");
	end

	// toggle once per half period while running, park at idle otherwise
	always_comb
	begin
		next_count = count;
		next_level = level;
		if (!run)
		begin
			next_count = '0;
			next_level = idleLevel;
		end
		else if (count + 1'b1 >= halfPeriod)
		begin
			next_count = '0;
			next_level = ~level;
		end
		else
			next_count = count + 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			count <= '0;
			level <= 1'b0;
		end
		else
		begin
			count <= next_count;
			level <= next_level;
		end
	end

	assign skOut = run ? level : idleLevel;
endmodule

// ---- bench/sspc_serial_port_checker.sv ----
`timescale 1ns/1ps
module sspc_serial_port_checker (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// register writes
	input wire logic [7:0] memAddr,
	input wire logic memWrite,
	input wire logic [7:0] memWrData,
	// pins and status
	input wire logic [7:0] portOut,
	input wire logic [7:0] portOe,
	input wire logic busy
);
	logic [7:0] lat, dir, ctl, next_lat, next_dir, next_ctl;
	logic [3:0] quiet, pulses, gap, half, next_quiet, next_pulses, next_gap;
	logic sk, bq, master, leave;
	assign master = ctl[3] && dir[5];
	assign half = ctl[1] ? 4'h4 : (ctl[0] ? 4'h2 : 4'h1);
	assign leave = portOut[5] != sk && portOut[5] != lat[5];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// shadows; quiet saturates so only settled outputs are judged
	always_comb
	begin
		next_lat = (memWrite && memAddr == 8'hd4) ? memWrData : lat;
		next_dir = (memWrite && memAddr == 8'hd5) ? memWrData : dir;
		next_ctl = (memWrite && memAddr == 8'hee) ? memWrData : ctl;
		next_quiet = memWrite ? 4'h0 : quiet + {3'h0, quiet != 4'h3};
		next_pulses = (busy && !bq ? 4'h0 : pulses) + {3'h0, leave};
		next_gap = portOut[5] != sk ? 4'h1 : gap + 4'h1;
	end
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
			{lat, dir, ctl, quiet, pulses, gap, sk, bq} <= 38'h0;
		else
			{lat, dir, ctl, quiet, pulses, gap, sk, bq} <= {next_lat, next_dir, next_ctl,
				next_quiet, next_pulses, next_gap, portOut[5], busy};
	sequence statusWrite;
		memWrite && memAddr == 8'hef;
	endsequence
	busy_write_a: assert property (statusWrite |=> busy == $past(memWrData[2]))
		else $error("busy differs from written status");
	reset_state_a: assert property ($rose(rstn) |-> portOe == 8'h00 && !busy)
		else $error("outputs not cleared by reset");
	idle_level_a:
		assert property (master && !busy && !$past(busy, 2) && quiet == 4'h3 |-> portOut[5] == lat[5])
		else $error("clock not parked at idle level");
	port_route_a: assert property (quiet == 4'h3 && !ctl[3] |-> portOut == lat)
		else $error("pins not from latch");
	oe_map_a: assert property (quiet == 4'h3 |-> portOe == (ctl[3] ? dir & 8'hbf : dir))
		else $error("enables differ from direction");
	eight_pulses_a:
		assert property ($fell(busy) && master && !$past(memWrite) |-> pulses == 4'h8)
		else $error("transfer not eight pulses");
	half_period_a:
		assert property (master && busy && pulses != 4'h0 && portOut[5] != sk |-> gap == half)
		else $error("wrong clock half period");
	so_edge_a:
		assert property (master && busy && ctl[1] && quiet == 4'h3 && $changed(portOut[4])
			|-> $past(portOut[5]) == (dir[6] ^ lat[5]))
		else $error("serial out moved off drive edge");
endmodule
bind sspc_serial_port sspc_serial_port_checker i_sspc_serial_port_checker (.sys_clk(sys_clk),
	.rstn(rstn), .memAddr(memAddr), .memWrite(memWrite), .memWrData(memWrData),
	.portOut(portOut), .portOe(portOe), .busy(busy));

// ---- bench/sspc_peer_model.sv ----
`timescale 1ns/1ps
module sspc_peer_model (
	// pin levels seen by the peer
	input wire logic sk,
	input wire logic so,
	// mode, set like the device
	input wire logic phase,
	input wire logic idle,
	// lines driven by the peer
	output logic skPeer,
	output logic si
);
	logic [7:0] tx, rx;
	logic tog = 1'b0;
	initial si = 1'b0;
	// clock stands at idle outside frames
	assign skPeer = idle ^ tog;
	// leading-edge sampling needs the first bit before any edge
	task automatic load(input logic [7:0] b);
		si = phase ? ~b[7] : b[7];
		tx = phase ? b : {b[6:0], 1'b0};
		rx = 8'h00;
	endtask
	// eight pulses at the link rate
	task automatic frame();
		repeat (16)
		begin
			#62.5;
			tog = ~tog;
		end
		#62.5;
	endtask
	// drive on the selected edge, sample on the other
	always @(sk)
		if (sk == (phase ^ idle))
		begin
			si <= tx[7];
			tx <= {tx[6:0], ~tx[7]};
		end
		else
			rx <= {rx[6:0], so};
endmodule

// ---- bench/sspc_serial_port_tb.sv ----
`timescale 1ns/1ps
module sspc_serial_port_tb;
	logic sys_clk, rstn, memWrite, memRead, busy, skPeer, si, phase, idle;
	logic [7:0] memAddr, memWrData, memRdData, portOut, portOe, portIn, ext;
	logic [7:0] regs [5] = '{8'hd4, 8'hd5, 8'he9, 8'hee, 8'hef};
	int errors = 0, total_checks = 0;
	sspc_serial_port i_sspc_serial_port (.sys_clk(sys_clk), .rstn(rstn), .memAddr(memAddr),
		.memWrite(memWrite), .memWrData(memWrData), .memRead(memRead), .memRdData(memRdData),
		.portIn(portIn), .portOut(portOut), .portOe(portOe), .busy(busy));
	sspc_peer_model i_sspc_peer_model (.sk(portIn[5]), .so(portIn[4]), .phase(phase),
		.idle(idle), .skPeer(skPeer), .si(si));
	// undriven pins read the peer's si and clock on bits 6 and 5, a fixed pattern elsewhere
	assign ext = {1'b1, si, skPeer, 5'h15};
	assign portIn = (portOe & portOut) | (~portOe & ext);
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		{memAddr, memWrData, memWrite} = {a, d, 1'b1};
		@(negedge sys_clk);
		memWrite = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge sys_clk);
		{memAddr, memRead} = {a, 1'b1};
		@(negedge sys_clk);
		memRead = 1'b0;
		@(negedge sys_clk);
		check(memRdData, exp);
	endtask
	task automatic testRegs();
		foreach (regs[i])
			rd(regs[i], sspc_pkg::RESET_BYTE);
		rd(8'h80, sspc_pkg::UNMAPPED_READ);
		wr(8'hd6, 8'hff);
		rd(8'hd6, ext);
	endtask
	// one byte each way; fast rates are too quick for synced input data
	task automatic xfer(input logic ph, pol, input logic [7:0] dirv, ctl);
		int n;
		{phase, idle, n} = {ph, pol, 32'h0};
		wr(8'hd4, {2'b00, pol, 5'h00});
		wr(8'hd5, dirv | {1'b0, ph, 6'h00});
		wr(8'hee, ctl);
		wr(8'he9, 8'h3c);
		i_sspc_peer_model.load(8'hc5);
		wr(8'hef, 8'h04);
		if (!dirv[5])
			i_sspc_peer_model.frame();
		while (busy !== 1'b0 && n < 500)
		begin
			@(negedge sys_clk);
			n++;
		end
		check({7'h0, busy}, 8'h00);
		if (ctl[1] || !dirv[5])
		begin
			check(i_sspc_peer_model.rx, 8'h3c);
			rd(8'he9, 8'hc5);
		end
	endtask
	task automatic testAbort();
		wr(8'hef, 8'h04);
		repeat (12) @(negedge sys_clk);
		wr(8'hef, 8'h00);
		repeat (3) @(negedge sys_clk);
		check({6'h0, busy, portOut[5]}, {7'h0, idle});
		wr(8'hee, 8'h00);
		repeat (3) @(negedge sys_clk);
		check(portOut, 8'h20);
	endtask
	task automatic conclude();
		$display("checks %0d, errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		{rstn, memWrite, memRead, phase, idle, memAddr, memWrData} = 21'h0;
		repeat (16) @(negedge sys_clk);
		rstn = 1'b1;
		testRegs();
		xfer(1'b1, 1'b0, 8'h10, 8'h08);
		xfer(1'b0, 1'b1, 8'h10, 8'h08);
		xfer(1'b0, 1'b0, 8'h30, 8'h08);
		xfer(1'b0, 1'b0, 8'h30, 8'h09);
		for (int k = 0; k < 4; k++)
			xfer(k[0], k[1], 8'h30, 8'h0a);
		testAbort();
		conclude();
	end
	// the tests need well under 20k cycles
	initial
	begin
		#160000;
		errors++;
		conclude();
	end
endmodule
